// ### core/ctm_pkg.sv
// Shared constants for the compact timer: register map, field positions and encodings.
package ctm_pkg;
   localparam int CTM_CNT_W = 10;
   localparam int CTM_COMPARE_P_VALUE_W = 3;
   localparam int CTM_ADDR_W = 3;
   localparam int CTM_DATA_W = 8;
   // Register offsets.
   localparam logic [2:0] CTM_OFS_CTRL0 = 3'h0;
   localparam logic [2:0] CTM_OFS_TIMER_CONTROL_ONE = 3'h1;
   localparam logic [2:0] CTM_OFS_CMPA_LO = 3'h2;
   localparam logic [2:0] CTM_OFS_CMPA_HI = 3'h3;
   localparam logic [2:0] CTM_OFS_CNT_LO = 3'h4;
   localparam logic [2:0] CTM_OFS_CNT_HI = 3'h5;
   localparam logic [2:0] CTM_OFS_FLAGS = 3'h6;
   // Field positions.
   localparam int CTM_BIT_COUNTER_ON = 3;
   localparam int CTM_BIT_MODE_HIGH = 7;
   localparam int CTM_BIT_MODE_LOW = 6;
   localparam int CTM_BIT_OFN_HIGH = 5;
   localparam int CTM_BIT_OFN_LOW = 4;
   localparam int CTM_BIT_LEVEL_CTRL = 3;
   localparam int CTM_BIT_INVERT = 2;
   localparam int CTM_BIT_SWAP = 1;
   localparam int CTM_BIT_CLR_SEL = 0;
   localparam int CTM_BIT_FLAG_A = 0;
   localparam int CTM_BIT_FLAG_P = 1;
   // Reset values.
   localparam logic [7:0] CTM_RST_CTRL1 = 8'h00;
   localparam logic [2:0] CTM_RST_COMPARE_P_VALUE = 3'h0;
   localparam logic [9:0] CTM_RST_COMPARE_A_VALUE = 10'h000;
   // Mode and output function encodings.
   localparam logic [1:0] CTM_MODE_CMP = 2'h0;
   localparam logic [1:0] CTM_MODE_PWM = 2'h2;
   localparam logic [1:0] CTM_MODE_TMR = 2'h3;
   localparam logic [1:0] CTM_OFN_00 = 2'h0;
   localparam logic [1:0] CTM_OFN_01 = 2'h1;
   localparam logic [1:0] CTM_OFN_10 = 2'h2;
   localparam logic [1:0] CTM_OFN_11 = 2'h3;
   // Comparator P steps in blocks of 128 clocks, each ending on these seven low ones; code zero means the full count.
   localparam logic [6:0] CTM_P_LOW_ONES = 7'h7f;
   localparam logic [10:0] CTM_FULL_COUNT = 11'h400;
endpackage

// ### core/ctm_core_if.sv
// Control and compare signals shared between the timer's register file, counter and pin logic.
`timescale 1ns/1ns
interface ctm_core_if;
   logic on;
   logic [1:0] mode;
   logic [1:0] ofn;
   logic oc;
   logic pol;
   logic swap;
   logic clr_sel;
   logic [9:0] compare_a_value;
   logic [2:0] compare_p_value;
   logic [9:0] cnt;
   logic run;
   logic on_rise;
   logic a_hit;
   logic p_hit;
   modport top_mp (output on, mode, ofn, oc, pol, swap, clr_sel, compare_a_value, compare_p_value,
      input cnt, run, on_rise, a_hit, p_hit);
   modport ctr_mp (input on, mode, swap, clr_sel, compare_a_value, compare_p_value,
      output cnt, run, on_rise, a_hit, p_hit);
   modport pin_mp (input mode, ofn, oc, pol, swap, compare_a_value, compare_p_value, cnt, run, on_rise, a_hit);
endinterface

// ### core/ctm_counter.sv
// Ten-bit up counter with comparator A and comparator P match detection.
`timescale 1ns/1ns
module ctm_counter
(
   input wire logic clk,
   input wire logic rst_b,
   ctm_core_if.ctr_mp cb
);
   import ctm_pkg::*;
   logic on_d_r;
   logic [9:0] cnt_r;
   logic [9:0] p_top;
   logic clear;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         on_d_r <= 1'b0;
      else
         on_d_r <= cb.on;
   end

   assign cb.on_rise = cb.on & ~on_d_r;
   assign cb.run = cb.on & on_d_r;
   // Last count before the P boundary; code zero wraps to the full ten-bit count.
   assign p_top = {cb.compare_p_value - 3'h1, CTM_P_LOW_ONES};
   // A value of zero never matches, so the counter just overflows.
   assign cb.a_hit = cb.run && (cb.compare_a_value != 10'h000) && (cnt_r == cb.compare_a_value - 10'h001);
   assign cb.p_hit = cb.run && (cnt_r == p_top);
   always_comb
   begin
      if (cb.mode == CTM_MODE_PWM)
         clear = cb.swap ? cb.a_hit : cb.p_hit;
      else
         clear = cb.clr_sel ? cb.a_hit : cb.p_hit;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         cnt_r <= 10'h000;
      else if (cb.on_rise)
         cnt_r <= 10'h000;
      else if (cb.run)
         cnt_r <= clear ? 10'h000 : cnt_r + 10'h001;
   end
   assign cb.cnt = cnt_r;
endmodule

// ### core/ctm_outpin.sv
// Drives the timer output pin in compare match and PWM modes.
`timescale 1ns/1ns
module ctm_outpin
(
   input wire logic clk,
   input wire logic rst_b,
   ctm_core_if.pin_mp cb,
   output logic pin_o,
   output logic pin_oe
);
   import ctm_pkg::*;
   logic lvl_r;
   logic lvl_nxt;
   logic pwm_lvl;
   logic active;
   logic [10:0] p_val;
   logic [10:0] duty;

   assign p_val = {cb.compare_p_value == 3'h0, cb.compare_p_value, 7'h00};
   assign duty = cb.swap ? p_val : {1'b0, cb.compare_a_value};
   // The count never reaches the period, so a duty at or above it stays active.
   assign active = {1'b0, cb.cnt} < duty;

   always_comb
   begin
      unique case (cb.ofn)
         CTM_OFN_01: pwm_lvl = cb.oc;
         CTM_OFN_10: pwm_lvl = active ? cb.oc : ~cb.oc;
         default: pwm_lvl = ~cb.oc;
      endcase
   end

   always_comb
   begin
      lvl_nxt = lvl_r;
      if (cb.on_rise)
         lvl_nxt = cb.oc;
      else if (cb.a_hit)
      begin
         unique case (cb.ofn)
            CTM_OFN_00: lvl_nxt = lvl_r;
            CTM_OFN_01: lvl_nxt = 1'b0;
            CTM_OFN_10: lvl_nxt = 1'b1;
            CTM_OFN_11: lvl_nxt = ~lvl_r;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         lvl_r <= 1'b0;
      else
         lvl_r <= lvl_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pin_o <= 1'b0;
         pin_oe <= 1'b0;
      end
      else
      begin
         pin_o <= ((cb.mode == CTM_MODE_PWM) ? pwm_lvl : lvl_nxt) ^ cb.pol;
         pin_oe <= (cb.mode != CTM_MODE_TMR);
      end
   end
endmodule

// ### core/ctm_top.sv
// Compact ten-bit timer with compare match, timer/counter and PWM modes.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns

module ctm_top
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic [ctm_pkg::CTM_ADDR_W-1:0] ADDR,
   input wire logic [ctm_pkg::CTM_DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [ctm_pkg::CTM_DATA_W-1:0] RDATA,
   output logic TIMER_OUTPUT_PIN_O,
   output logic TIMER_OUTPUT_PIN_OE
);
   import ctm_pkg::*;

   logic counter_on_r;
   logic [2:0] compare_p_value_r;
   logic [7:0] timer_control_one_r;
   logic [9:0] compare_a_value_r;
   logic compare_a_match_flag_r;
   logic compare_p_match_flag_r;
   logic [7:0] rdata_nxt;
   logic wr_flags;
   logic is_pwm;
   logic [10:0] chk_period;
   logic [10:0] chk_duty;

   ctm_core_if cb ();

   assign cb.on = counter_on_r;
   assign cb.mode = timer_control_one_r[CTM_BIT_MODE_HIGH:CTM_BIT_MODE_LOW];
   assign cb.ofn = timer_control_one_r[CTM_BIT_OFN_HIGH:CTM_BIT_OFN_LOW];
   assign cb.oc = timer_control_one_r[CTM_BIT_LEVEL_CTRL];
   assign cb.pol = timer_control_one_r[CTM_BIT_INVERT];
   assign cb.swap = timer_control_one_r[CTM_BIT_SWAP];
   assign cb.clr_sel = timer_control_one_r[CTM_BIT_CLR_SEL];
   assign cb.compare_a_value = compare_a_value_r;
   assign cb.compare_p_value = compare_p_value_r;
   assign is_pwm = (cb.mode == CTM_MODE_PWM);

   ctm_counter u_counter
   (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .cb(cb.ctr_mp)
   );

   ctm_outpin u_outpin
   (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .cb(cb.pin_mp),
      .pin_o(TIMER_OUTPUT_PIN_O),
      .pin_oe(TIMER_OUTPUT_PIN_OE)
   );

   // Control register writes.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B)
      begin
         counter_on_r <= 1'b0;
         compare_p_value_r <= CTM_RST_COMPARE_P_VALUE;
      end
      else if (WR && ADDR == CTM_OFS_CTRL0)
      begin
         counter_on_r <= WDATA[CTM_BIT_COUNTER_ON];
         compare_p_value_r <= WDATA[2:0];
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B)
         timer_control_one_r <= CTM_RST_CTRL1;
      else if (WR && ADDR == CTM_OFS_TIMER_CONTROL_ONE)
         timer_control_one_r <= WDATA;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B)
         compare_a_value_r <= CTM_RST_COMPARE_A_VALUE;
      else if (WR && ADDR == CTM_OFS_CMPA_LO)
         compare_a_value_r[7:0] <= WDATA;
      else if (WR && ADDR == CTM_OFS_CMPA_HI)
         compare_a_value_r[9:8] <= WDATA[1:0];
   end

   // Flags clear by writing one; a match in the same cycle wins over the clear.
   assign wr_flags = WR && (ADDR == CTM_OFS_FLAGS);

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B)
         compare_a_match_flag_r <= 1'b0;
      else if (cb.a_hit)
         compare_a_match_flag_r <= 1'b1;
      else if (wr_flags && WDATA[CTM_BIT_FLAG_A])
         compare_a_match_flag_r <= 1'b0;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B)
         compare_p_match_flag_r <= 1'b0;
      else if (cb.p_hit && (is_pwm || !cb.clr_sel))
         compare_p_match_flag_r <= 1'b1;
      else if (wr_flags && WDATA[CTM_BIT_FLAG_P])
         compare_p_match_flag_r <= 1'b0;
   end

   // Read data stands only in the cycle after the read strobe.
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (RD)
      begin
         unique case (ADDR)
            CTM_OFS_CTRL0: rdata_nxt = {4'h0, counter_on_r, compare_p_value_r};
            CTM_OFS_TIMER_CONTROL_ONE: rdata_nxt = timer_control_one_r;
            CTM_OFS_CMPA_LO: rdata_nxt = compare_a_value_r[7:0];
            CTM_OFS_CMPA_HI: rdata_nxt = {6'h00, compare_a_value_r[9:8]};
            CTM_OFS_CNT_LO: rdata_nxt = cb.cnt[7:0];
            CTM_OFS_CNT_HI: rdata_nxt = {6'h00, cb.cnt[9:8]};
            CTM_OFS_FLAGS: rdata_nxt = {6'h00, compare_p_match_flag_r, compare_a_match_flag_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B)
         RDATA <= 8'h00;
      else
         RDATA <= rdata_nxt;
   end

   // Period and duty in clocks, rebuilt here only for the pin and counter checks below.
   assign chk_period = cb.swap ? ((cb.compare_a_value == 10'h000) ? CTM_FULL_COUNT : {1'b0, cb.compare_a_value})
      : ((cb.compare_p_value == 3'h0) ? CTM_FULL_COUNT : {1'b0, cb.compare_p_value, 7'h00});
   assign chk_duty = cb.swap ? ((cb.compare_p_value == 3'h0) ? CTM_FULL_COUNT : {1'b0, cb.compare_p_value, 7'h00})
      : {1'b0, cb.compare_a_value};

   AST_CMP_A_CLEAR: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (!is_pwm && cb.clr_sel && cb.a_hit) |=> (cb.cnt == 10'h000))
      else $error("Comparator A match did not clear the counter.");

   AST_CMP_P_NO_PIN: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (cb.mode == CTM_MODE_CMP && cb.p_hit && !cb.a_hit && !cb.on_rise && !WR)
      |=> $stable(TIMER_OUTPUT_PIN_O))
      else $error("Comparator P match moved the output pin.");

   AST_ON_RISE_INIT: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (cb.mode == CTM_MODE_CMP && cb.on_rise)
      |=> (TIMER_OUTPUT_PIN_O == ($past(cb.oc) ^ $past(cb.pol))))
      else $error("Counter-on rising edge did not restore the initial level.");

   AST_NO_P_FLAG: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (!is_pwm && cb.clr_sel && !compare_p_match_flag_r) |=> !compare_p_match_flag_r)
      else $error("P flag raised while A match clears the counter.");

   AST_TMR_FLAGS: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (cb.mode == CTM_MODE_TMR && cb.a_hit) |=> compare_a_match_flag_r)
      else $error("Timer mode missed the A flag.");

   AST_TMR_RELEASE: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (cb.mode == CTM_MODE_TMR) |=> !TIMER_OUTPUT_PIN_OE)
      else $error("Timer mode still drives the output pin.");

   AST_PWM_DRIVE: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      is_pwm |=> TIMER_OUTPUT_PIN_OE)
      else $error("PWM mode does not drive the output pin.");

   AST_PWM_PERIOD_CLEAR: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && (cb.swap ? cb.a_hit : cb.p_hit)) |=> (cb.cnt == 10'h000))
      else $error("PWM period comparator did not clear the counter.");

   AST_PWM_DUTY_NO_CLEAR: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && cb.swap && cb.p_hit && !cb.a_hit)
      |=> (cb.cnt == $past(cb.cnt) + 10'h001))
      else $error("PWM duty comparator cleared the counter.");

   AST_P_STEP: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      cb.p_hit |-> ({1'b0, cb.cnt} + 11'h001 == chk_period) || cb.swap)
      else $error("Comparator P period is not 128 clocks per step.");

   AST_FULL_DUTY: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && cb.ofn == CTM_OFN_10 && chk_duty >= chk_period && !WR)
      |=> (TIMER_OUTPUT_PIN_O == ($past(cb.oc) ^ $past(cb.pol))))
      else $error("Full duty did not keep the output active.");

   AST_PWM_P_FLAG: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && cb.p_hit) |=> compare_p_match_flag_r)
      else $error("PWM missed the P flag.");

   AST_FORCE_LEVEL: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && (cb.ofn == CTM_OFN_00 || cb.ofn == CTM_OFN_01))
      |=> (TIMER_OUTPUT_PIN_O == (($past(cb.ofn == CTM_OFN_01) ~^ $past(cb.oc))
         ^ $past(cb.pol))))
      else $error("Forced PWM level is wrong.");

   AST_FORCED_RUNS: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && cb.run && cb.ofn != CTM_OFN_10 && !cb.a_hit && !cb.p_hit)
      ##1 cb.run |-> (cb.cnt == $past(cb.cnt) + 10'h001))
      else $error("Counter stopped while the pin level was forced.");

   AST_PWM_WAVE: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && cb.ofn == CTM_OFN_10 && !WR)
      |=> (TIMER_OUTPUT_PIN_O == ((($past({1'b0, cb.cnt}) < $past(chk_duty)) ~^ $past(cb.oc))
         ^ $past(cb.pol))))
      else $error("PWM waveform level does not follow the duty count.");

   AST_CMP_A_HIGH: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (cb.mode == CTM_MODE_CMP && cb.a_hit && !cb.on_rise && cb.ofn == CTM_OFN_10)
      |=> (TIMER_OUTPUT_PIN_O == ~$past(cb.pol)))
      else $error("Comparator A match did not drive the pin high.");

   // The pin lags the level by one cycle, so the keep and toggle checks want a steady mode and polarity.
   AST_CMP_A_KEEP: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (cb.mode == CTM_MODE_CMP && $stable(cb.mode) && $stable(cb.pol) && cb.a_hit
         && cb.ofn == CTM_OFN_00) |=> $stable(TIMER_OUTPUT_PIN_O))
      else $error("Comparator A match moved the pin with no change selected.");

   AST_CMP_A_LOW: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (cb.mode == CTM_MODE_CMP && cb.a_hit && cb.ofn == CTM_OFN_01)
      |=> (TIMER_OUTPUT_PIN_O == $past(cb.pol)))
      else $error("Comparator A match did not drive the pin low.");

   AST_CMP_A_TOGGLE: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (cb.mode == CTM_MODE_CMP && $stable(cb.mode) && $stable(cb.pol) && cb.a_hit
         && cb.ofn == CTM_OFN_11) |=> (TIMER_OUTPUT_PIN_O != $past(TIMER_OUTPUT_PIN_O)))
      else $error("Comparator A match did not toggle the pin.");

   AST_CMP_P_FLAG: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (!is_pwm && !cb.clr_sel && cb.p_hit) |=> compare_p_match_flag_r)
      else $error("P match missed its flag while P clears the counter.");

   AST_TMR_CLEAR: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (cb.mode == CTM_MODE_TMR && !cb.clr_sel && cb.p_hit) |=> (cb.cnt == 10'h000))
      else $error("Timer mode P match did not clear the counter.");

   AST_PWM_A_FLAG: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && cb.a_hit) |=> compare_a_match_flag_r)
      else $error("PWM missed the A flag.");

   AST_P_TOP_BITS: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      cb.p_hit |-> (cb.cnt[6:0] == CTM_P_LOW_ONES && cb.cnt[9:7] + 3'h1 == cb.compare_p_value))
      else $error("P match does not sit on the top counter bits.");

   AST_PWM_CODE_11: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && cb.ofn == CTM_OFN_11)
      |=> (TIMER_OUTPUT_PIN_O == (~$past(cb.oc) ^ $past(cb.pol))))
      else $error("Unused PWM output code did not hold the inactive level.");

   AST_SWAP_FULL_PERIOD: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (is_pwm && cb.swap && cb.compare_a_value == 10'h000 && cb.run && cb.cnt == 10'h3ff)
      |=> (cb.cnt == 10'h000))
      else $error("A value of zero did not give the full period.");
endmodule

// ### verification/ctm_load_model.sv
// Load on the timer output pin that resolves the pin level and counts high cycles in a window.
`timescale 1ns/1ns
module ctm_load_model
(
   input wire logic clk,
   input wire logic pin_o,
   input wire logic pin_oe,
   input wire logic meas_en,
   output logic pin_lvl,
   output logic [15:0] high_cnt
);
   // The load has a pull-down, so a released pin reads low instead of a stale level.
   assign pin_lvl = pin_oe ? pin_o : 1'b0;

   always_ff @(posedge clk)
   begin
      if (!meas_en)
      begin
         high_cnt <= 16'h0000;
      end
      else if (pin_lvl)
      begin
         high_cnt <= high_cnt + 16'h0001;
      end
   end
endmodule

// ### verification/ctm_top_test.sv
// Self-checking bench for the compact timer: register tasks, compare, timer and PWM scenarios.
`timescale 1ns/1ns
module ctm_top_test;
   import ctm_pkg::*;
   logic clk_sys;
   logic rst_b;
   logic [CTM_ADDR_W-1:0] addr;
   logic [CTM_DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [CTM_DATA_W-1:0] rdata;
   logic pin_o;
   logic pin_oe;
   logic meas_en;
   logic pin_lvl;
   logic [15:0] high_cnt;
   int n_errors = 0;
   int checked = 0;
   // Compare mode table: output function 00 and 01 start high, 10 and 11 start low.
   localparam logic [3:0][7:0] CMP_CFG = {8'h31, 8'h21, 8'h19, 8'h09};
   localparam logic [3:0] CMP_PIN = 4'b1101;
   localparam logic [7:0][7:0] PWM_CFG = {8'hb8, 8'h88, 8'h98, 8'ha8, 8'ha0, 8'hac, 8'ha9, 8'ha8};
   localparam logic [7:0][9:0] PWM_A = {10'd32, 10'd32, 10'd32, 10'd200, 10'd32, 10'd32, 10'd32,
      10'd32};
   localparam logic [7:0][15:0] PWM_HI = {16'd0, 16'd0, 16'd512, 16'd512, 16'd384, 16'd384,
      16'd128, 16'd128};

   ctm_top dut
   (
      .CLK_SYS(clk_sys),
      .RST_B(rst_b),
      .ADDR(addr),
      .WDATA(wdata),
      .WR(wr),
      .RD(rd),
      .RDATA(rdata),
      .TIMER_OUTPUT_PIN_O(pin_o),
      .TIMER_OUTPUT_PIN_OE(pin_oe)
   );

   ctm_load_model load
   (
      .clk(clk_sys),
      .pin_o(pin_o),
      .pin_oe(pin_oe),
      .meas_en(meas_en),
      .pin_lvl(pin_lvl),
      .high_cnt(high_cnt)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic end_sim();
      $display("Mismatches %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      check({8'h00, rdata}, {8'h00, exp});
   endtask

   // Reconfigures with the counter stopped, since mode changes while running are unpredictable.
   task automatic start(input logic [7:0] cfg, input logic [2:0] p, input logic [9:0] a);
      reg_wr(CTM_OFS_CTRL0, 8'h00);
      reg_wr(CTM_OFS_FLAGS, 8'h03);
      reg_wr(CTM_OFS_TIMER_CONTROL_ONE, cfg);
      reg_wr(CTM_OFS_CMPA_LO, a[7:0]);
      reg_wr(CTM_OFS_CMPA_HI, {6'h00, a[9:8]});
      reg_wr(CTM_OFS_CTRL0, {5'h01, p});
   endtask

   task automatic meas(input int win, input logic [15:0] exp);
      @(posedge clk_sys);
      meas_en <= 1'b1;
      repeat (win) @(posedge clk_sys);
      meas_en <= 1'b0;
      #1;
      check(high_cnt, exp);
   endtask

   initial
   begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      end_sim();
   end

   initial
   begin
      rst_b = 1'b0;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      meas_en = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++)
         reg_rd(i[2:0], 8'h00);
      reg_wr(CTM_OFS_CNT_LO, 8'hff);
      reg_wr(3'h7, 8'hff);
      reg_rd(CTM_OFS_CNT_LO, 8'h00);
      reg_rd(3'h7, 8'h00);
      reg_wr(CTM_OFS_TIMER_CONTROL_ONE, 8'h5a);
      reg_rd(CTM_OFS_TIMER_CONTROL_ONE, 8'h5a);
      // Clear on A with A at 200 and P code 1: P still matches at 127 but neither clears the counter nor sets its flag.
      for (int i = 0; i < 4; i++)
      begin
         start(CMP_CFG[i], 3'h1, 10'd200);
         repeat (5) @(posedge clk_sys);
         #1;
         check({15'h0, pin_o}, {15'h0, CMP_CFG[i][3]});
         check({15'h0, pin_oe}, 16'h0001);
         repeat (295) @(posedge clk_sys);
         #1;
         check({15'h0, pin_o}, {15'h0, CMP_PIN[i]});
         if (i == 3)
         begin
            repeat (200) @(posedge clk_sys);
            #1;
            check({15'h0, pin_o}, 16'h0000);
         end
         reg_rd(CTM_OFS_FLAGS, 8'h01);
         reg_rd(CTM_OFS_CNT_HI, 8'h00);
      end
      start(8'h20, 3'h1, 10'd600);
      repeat (300) @(posedge clk_sys);
      #1;
      check({15'h0, pin_o}, 16'h0000);
      reg_rd(CTM_OFS_FLAGS, 8'h02);
      reg_rd(CTM_OFS_CNT_HI, 8'h00);
      start(8'hc0, 3'h1, 10'd64);
      repeat (300) @(posedge clk_sys);
      #1;
      check({15'h0, pin_oe}, 16'h0000);
      reg_rd(CTM_OFS_FLAGS, 8'h03);
      reg_rd(CTM_OFS_CNT_HI, 8'h00);
      // Period of 128 clocks from P code 1; four whole periods make the count phase-free.
      for (int i = 0; i < 8; i++)
      begin
         start(PWM_CFG[i], 3'h1, PWM_A[i]);
         repeat (20) @(posedge clk_sys);
         meas(512, PWM_HI[i]);
      end
      reg_wr(CTM_OFS_FLAGS, 8'h03);
      repeat (200) @(posedge clk_sys);
      reg_rd(CTM_OFS_FLAGS, 8'h03);
      // Swapped roles: A of zero gives a 1024 clock period, P code sets the duty.
      for (int c = 0; c < 8; c++)
      begin
         start(8'haa, c[2:0], 10'd0);
         repeat (20) @(posedge clk_sys);
         meas(1024, (c == 0) ? 16'd1024 : 16'(c * 128));
      end
      end_sim();
   end
endmodule
